// >>> scr_peer.sv
// Purpose: Behavioural SPI slave facing the block's master pins.
// Assumes: Format and bit order come from the bench's mode byte.
// Notes: A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module scr_peer (
	// Serial pins
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_sel_n,
	output logic o_miso,
	// Format and data
	input wire logic [7:0] i_mode,
	input wire logic [7:0] i_tx,
	output logic [7:0] o_rx
);
	// Next reply bit to put out
	int idx;
	// Reply bit k in the chosen order
	function automatic logic pick(input int k);
		return i_mode[5] ? i_tx[k] : i_tx[7 - k];
	endfunction
	// Select fall loads, rise releases the line with a changed level
	always @(i_sel_n)
	begin
		idx = i_mode[2] ? 0 : 1;
		o_miso = i_sel_n ? ~o_miso : pick(0);
	end
	// Sample or shift by phase and by leaving the idle level
	always @(i_sck)
	begin
		if (!i_sel_n)
		begin
			if ((i_sck != i_mode[3]) ^ i_mode[2])
				o_rx = i_mode[5] ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
			else if (idx < 8)
			begin
				o_miso = pick(idx);
				idx++;
			end
		end
	end
endmodule // scr_peer
`default_nettype wire

// >>> scr_pkg.sv
// Purpose: Constants for the SPI control register block.
// Assumes: Wishbone byte addresses are four times a register index.
// Notes: Rate half-periods are in core clock cycles.
// What this block does
// - Interrupt needs enable, done flag, global enable.
// - Port enable bit gates every SPI operation.
// - Bit-order bit one sends LSB first.
// - Master-select bit picks master or slave.
// - Select low as input: drop master, flag.
// - Eight read/write control bits, reset zero.
// - Polarity and phase give four clock formats.
`default_nettype none
package scr_pkg;
	// Register indexes, byte address is index times four
	localparam logic [5:0] CTRL_INDEX = 6'h0D;
	localparam logic [5:0] STATUS_INDEX = 6'h0E;
	localparam logic [5:0] DATA_INDEX = 6'h0F;
	// Control field positions
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_PORT_EN = 6;
	localparam int BIT_LSB_FIRST = 5;
	localparam int BIT_MASTER = 4;
	localparam int BIT_POLARITY = 3;
	localparam int BIT_PHASE = 2;
	localparam int BIT_RATE_HI = 1;
	localparam int BIT_RATE_LO = 0;
	// Status field position
	localparam int BIT_DONE_FLAG = 7;
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [23:0] UPPER_ZERO = 24'h00_0000;
	// Synchroniser reset levels: {select, clock, mosi, miso}
	localparam logic [3:0] SYNC_INIT = 4'h8;
	// Serial clock half periods minus one, per rate code
	localparam logic [6:0] HALF_RATE0 = 7'h01;
	localparam logic [6:0] HALF_RATE1 = 7'h07;
	localparam logic [6:0] HALF_RATE2 = 7'h1F;
	localparam logic [6:0] HALF_RATE3 = 7'h3F;
	localparam logic [6:0] COUNT_ZERO = 7'h00;
	localparam logic [6:0] COUNT_ONE = 7'h01;
	// Sixteen clock edges per byte
	localparam logic [3:0] EDGE_FIRST = 4'h0;
	localparam logic [3:0] EDGE_LAST = 4'hF;
	localparam logic [3:0] EDGE_STEP = 4'h1;
endpackage : scr_pkg
`default_nettype wire

// >>> scr_sync.sv
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to i_clock.
// Notes: A change is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module scr_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Raw and filtered levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] st1_r; // Read only by stage two
	logic [WIDTH-1:0] st2_r;
	logic [WIDTH-1:0] st3_r;
	logic [WIDTH-1:0] level_r;
	logic [WIDTH-1:0] level_nxt;

	// Per bit, follow only once the last two stages agree
	always_comb
	begin
		level_nxt = level_r;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st2_r[i] == st3_r[i])
				level_nxt[i] = st3_r[i];
		end
	end

	// Stages and filtered output
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st1_r <= INIT;
			st2_r <= INIT;
			st3_r <= INIT;
			level_r <= INIT;
		end
		else
		begin
			st1_r <= i_async;
			st2_r <= st1_r;
			st3_r <= st2_r;
			level_r <= level_nxt;
		end
	end

	assign o_level = level_r;
endmodule // scr_sync
`default_nettype wire

// >>> scr_top.sv
// Purpose: SPI control register with a byte shifter behind it.
// Assumes: Classic Wishbone, registers in data lane zero.
// Notes: Mode fault beats a software write to master select.
`timescale 1ns/1ps
`default_nettype none
module scr_top (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Core side
	input wire logic i_global_irq_enable,
	input wire logic i_ss_is_input,
	output logic o_spi_irq,
	// SPI pins
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_miso,
	input wire logic i_ss_n,
	output logic o_sck,
	output logic o_sck_oe,
	output logic o_mosi,
	output logic o_mosi_oe,
	output logic o_miso,
	output logic o_miso_oe
);
	// Synchronised pin levels
	logic [3:0] pins_s;
	logic ss_s;
	logic sck_s;
	logic mosi_s;
	logic miso_s;
	// Registered state and next values
	logic [7:0] ctrl_r, ctrl_nxt; // Control register
	logic flag_r, flag_nxt; // Transfer done flag
	logic [7:0] tx_buf_r, tx_buf_nxt; // Byte to send
	logic [7:0] rx_data_r, rx_data_nxt; // Last byte received
	logic [7:0] shift_r, shift_nxt; // Outgoing bits
	logic [7:0] rx_shift_r, rx_shift_nxt; // Incoming bits
	logic busy_r, busy_nxt;
	logic [3:0] edge_r, edge_nxt; // Serial clock edge index
	logic sck_r, sck_nxt;
	logic out_r, out_nxt; // Serial data out
	logic [6:0] div_r, div_nxt; // Half period counter
	logic ack_r, ack_nxt;
	logic [7:0] rdat_r, rdat_nxt;
	logic sck_prev_r, ss_prev_r;
	// Decoded strobes and events
	logic bus_hit, wr, wr_ctrl, wr_status, wr_data;
	logic [5:0] idx;
	logic [7:0] wbyte;
	logic en, is_master, clock_polarity, clock_phase, lsb;
	logic fault, tick, slave_act, sck_edge;
	logic lead_ev, trail_ev, sample_ev, out_ev, done;
	logic go_m, go_s, start;
	logic [7:0] ld, src;
	logic in_bit;
	logic [6:0] half_m1;

	// Filter all four pins; select idles high
	scr_sync #(
		.WIDTH(4),
		.INIT(scr_pkg::SYNC_INIT)
	) u_sync (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_async({i_ss_n, i_sck, i_mosi, i_miso}),
		.o_level(pins_s)
	);
	assign {ss_s, sck_s, mosi_s, miso_s} = pins_s;

	// Bus decode, one ack per request
	assign bus_hit = i_wb_cyc & i_wb_stb & ~ack_r;
	assign wr = bus_hit & i_wb_we & i_wb_sel[0];
	assign idx = i_wb_adr[7:2];
	assign wbyte = i_wb_dat[7:0];
	assign wr_ctrl = wr & (idx == scr_pkg::CTRL_INDEX);
	assign wr_status = wr & (idx == scr_pkg::STATUS_INDEX);
	assign wr_data = wr & (idx == scr_pkg::DATA_INDEX);

	// Control fields
	assign en = ctrl_r[scr_pkg::BIT_PORT_EN];
	assign is_master = ctrl_r[scr_pkg::BIT_MASTER];
	assign clock_polarity = ctrl_r[scr_pkg::BIT_POLARITY];
	assign clock_phase = ctrl_r[scr_pkg::BIT_PHASE];
	assign lsb = ctrl_r[scr_pkg::BIT_LSB_FIRST];

	// Rate code to half period
	always_comb
	begin
		case ({ctrl_r[scr_pkg::BIT_RATE_HI], ctrl_r[scr_pkg::BIT_RATE_LO]})
			2'h0: half_m1 = scr_pkg::HALF_RATE0;
			2'h1: half_m1 = scr_pkg::HALF_RATE1;
			2'h2: half_m1 = scr_pkg::HALF_RATE2;
			default: half_m1 = scr_pkg::HALF_RATE3;
		endcase
	end

	// Events; a slave edge counts only while selected
	assign fault = en & is_master & i_ss_is_input & ~ss_s;
	assign tick = busy_r & is_master & (div_r == scr_pkg::COUNT_ZERO);
	assign slave_act = en & ~is_master & ~ss_s & busy_r;
	assign sck_edge = sck_s ^ sck_prev_r;
	// Leading edge leaves the idle level, trailing returns to it
	assign lead_ev = is_master ? (tick & ~edge_r[0])
		: (slave_act & sck_edge & (sck_s != clock_polarity));
	assign trail_ev = is_master ? (tick & edge_r[0])
		: (slave_act & sck_edge & (sck_s == clock_polarity));
	assign go_m = wr_data & en & is_master & ~busy_r;
	assign go_s = en & ~is_master & ss_prev_r & ~ss_s & ~busy_r;
	assign start = go_m | go_s;
	assign done = trail_ev & (edge_r == scr_pkg::EDGE_LAST);
	// Phase zero samples on leading edges, phase one on trailing
	assign sample_ev = clock_phase ? trail_ev : lead_ev;
	assign out_ev = (start & ~clock_phase) | (lead_ev & clock_phase)
		| (trail_ev & ~clock_phase & ~done);
	assign ld = go_m ? wbyte : tx_buf_r;
	assign src = start ? ld : shift_r;
	assign in_bit = is_master ? miso_s : mosi_s;

	// Register file next values; hardware events win
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		flag_nxt = flag_r;
		tx_buf_nxt = tx_buf_r;
		if (wr_ctrl)
			ctrl_nxt = wbyte;
		if (fault)
			ctrl_nxt[scr_pkg::BIT_MASTER] = 1'b0;
		if (wr_status & wbyte[scr_pkg::BIT_DONE_FLAG])
			flag_nxt = 1'b0;
		// Set after clear so a same-cycle event is kept
		if ((done & busy_r) | fault)
			flag_nxt = 1'b1;
		if (wr_data)
			tx_buf_nxt = wbyte;
	end

	// Shifter next values
	always_comb
	begin
		busy_nxt = busy_r;
		edge_nxt = edge_r;
		shift_nxt = shift_r;
		rx_shift_nxt = rx_shift_r;
		rx_data_nxt = rx_data_r;
		out_nxt = out_r;
		sck_nxt = sck_r;
		div_nxt = div_r;
		if (start)
		begin
			busy_nxt = 1'b1;
			edge_nxt = scr_pkg::EDGE_FIRST;
			shift_nxt = ld;
			div_nxt = half_m1;
		end
		if (out_ev)
		begin
			// Send the chosen end, move the next bit into place
			out_nxt = lsb ? src[0] : src[7];
			shift_nxt = lsb ? {1'b0, src[7:1]} : {src[6:0], 1'b0};
		end
		if (sample_ev)
			rx_shift_nxt = lsb ? {in_bit, rx_shift_r[7:1]}
				: {rx_shift_r[6:0], in_bit};
		if (lead_ev | trail_ev)
			edge_nxt = edge_r + scr_pkg::EDGE_STEP;
		if (tick)
		begin
			sck_nxt = ~sck_r;
			div_nxt = half_m1;
		end
		else if (busy_r & ~start & (div_r != scr_pkg::COUNT_ZERO))
			div_nxt = div_r - scr_pkg::COUNT_ONE;
		if (done)
		begin
			busy_nxt = 1'b0;
			rx_data_nxt = rx_shift_nxt;
		end
		// Abort: port off, fault, or slave deselected mid-byte
		if (~en | fault | (~is_master & ss_s))
			busy_nxt = 1'b0;
		// Idle clock rests at the polarity level
		if (~busy_nxt)
			sck_nxt = clock_polarity;
	end

	// Read mux; unmapped offsets read zero and still ack
	always_comb
	begin
		ack_nxt = bus_hit;
		case (idx)
			scr_pkg::CTRL_INDEX: rdat_nxt = ctrl_r;
			scr_pkg::STATUS_INDEX:
				rdat_nxt = {flag_r, 7'h00};
			scr_pkg::DATA_INDEX: rdat_nxt = rx_data_r;
			default: rdat_nxt = scr_pkg::BYTE_ZERO;
		endcase
	end

	// State registers other than the check counters
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ctrl_r <= scr_pkg::CTRL_RESET;
			flag_r <= 1'b0;
			tx_buf_r <= scr_pkg::BYTE_ZERO;
			rx_data_r <= scr_pkg::BYTE_ZERO;
			shift_r <= scr_pkg::BYTE_ZERO;
			rx_shift_r <= scr_pkg::BYTE_ZERO;
			busy_r <= 1'b0;
			edge_r <= scr_pkg::EDGE_FIRST;
			sck_r <= 1'b0;
			out_r <= 1'b0;
			div_r <= scr_pkg::COUNT_ZERO;
			ack_r <= 1'b0;
			rdat_r <= scr_pkg::BYTE_ZERO;
			sck_prev_r <= 1'b0;
			ss_prev_r <= 1'b1;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			flag_r <= flag_nxt;
			tx_buf_r <= tx_buf_nxt;
			rx_data_r <= rx_data_nxt;
			shift_r <= shift_nxt;
			rx_shift_r <= rx_shift_nxt;
			busy_r <= busy_nxt;
			edge_r <= edge_nxt;
			sck_r <= sck_nxt;
			out_r <= out_nxt;
			div_r <= div_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
			sck_prev_r <= sck_s;
			ss_prev_r <= ss_s;
		end
	end

	// Outputs; drivers only on when the port is enabled
	assign o_wb_ack = ack_r;
	assign o_wb_dat = {scr_pkg::UPPER_ZERO, rdat_r};
	assign o_spi_irq = ctrl_r[scr_pkg::BIT_IRQ_EN] & flag_r
		& i_global_irq_enable;
	assign o_sck = sck_r;
	assign o_sck_oe = en & is_master;
	assign o_mosi = out_r;
	assign o_mosi_oe = en & is_master;
	assign o_miso = out_r;
	assign o_miso_oe = en & ~is_master & ~ss_s;

	// Cycles since the last clock tick or start, for checking only
	logic [6:0] gap_r;
	logic gap_ok_r;
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			gap_r <= scr_pkg::COUNT_ZERO;
			gap_ok_r <= 1'b0;
		end
		else
		begin
			gap_r <= (tick | start) ? scr_pkg::COUNT_ZERO
				: gap_r + scr_pkg::COUNT_ONE;
			// Stays valid from a tick or start until the rate may change
			gap_ok_r <= (tick | start | gap_ok_r) & ~wr_ctrl;
		end
	end

	property p_irq_gate;
		@(posedge i_clock) disable iff (!i_reset_n)
		$rose(flag_r) && ctrl_r[scr_pkg::BIT_IRQ_EN] && i_global_irq_enable
		|-> o_spi_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq not raised on flag");

	property p_disabled_idle;
		@(posedge i_clock) disable iff (!i_reset_n)
		!en |-> !o_sck_oe && !o_miso_oe ##1 !busy_r;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("activity while port disabled");

	property p_first_bit;
		@(posedge i_clock) disable iff (!i_reset_n)
		go_m && !clock_phase |=> o_mosi == (lsb ? $past(wbyte[0]) : $past(wbyte[7]));
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("wrong first data bit");

	property p_slave_quiet;
		@(posedge i_clock) disable iff (!i_reset_n)
		!is_master |-> !o_sck_oe && !o_mosi_oe
			##1 !$past(busy_r) || !busy_r || $stable(o_sck);
	endproperty
	a_slave_quiet: assert property (p_slave_quiet)
		else $error("slave drives master pins");

	property p_mode_fault;
		@(posedge i_clock) disable iff (!i_reset_n)
		fault |=> !ctrl_r[scr_pkg::BIT_MASTER] && flag_r && !busy_r;
	endproperty
	a_mode_fault: assert property (p_mode_fault)
		else $error("mode fault not handled");

	property p_ctrl_write;
		@(posedge i_clock) disable iff (!i_reset_n)
		wr_ctrl && !fault |=> ctrl_r == $past(wbyte) ##1 o_wb_dat[7:0]
			== ctrl_r || !$past(ack_r);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write lost");

	property p_idle_level;
		@(posedge i_clock) disable iff (!i_reset_n)
		!busy_r ##1 !busy_r && $stable(clock_polarity) |-> o_sck == clock_polarity;
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("idle clock level wrong");

	property p_rate_gap;
		@(posedge i_clock) disable iff (!i_reset_n)
		tick && gap_ok_r |-> gap_r == half_m1;
	endproperty
	a_rate_gap: assert property (p_rate_gap)
		else $error("serial clock half period wrong");
endmodule // scr_top
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the SPI control register block.
// Assumes: One idle cycle between bus requests.
// Notes: Slave link clock period is 160 ns, four core cycles a half.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] CA = {scr_pkg::CTRL_INDEX, 2'b00};
	localparam logic [7:0] SA = {scr_pkg::STATUS_INDEX, 2'b00};
	localparam logic [7:0] DA = {scr_pkg::DATA_INDEX, 2'b00};
	// Bus, core side and pins
	logic i_clock, i_reset_n, cyc, stb, we, ack, irq, gie, ssin;
	logic [7:0] adr, mode, peer_tx, peer_rx, rd;
	logic [31:0] wdat, rdat;
	logic sck_in, mosi_in, ss_n, sck, sck_oe, mosi, mosi_oe;
	logic miso_pin, miso, miso_oe;
	int errors, n_compared;
	int cyc_cnt = 0;
	scr_top uut (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_dat(wdat), .i_wb_sel(4'h1), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_global_irq_enable(gie), .i_ss_is_input(ssin), .o_spi_irq(irq),
		.i_sck(sck_in), .i_mosi(mosi_in), .i_miso(miso_pin), .i_ss_n(ss_n),
		.o_sck(sck), .o_sck_oe(sck_oe), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
		.o_miso(miso), .o_miso_oe(miso_oe));
	scr_peer peer (.i_sck(sck), .i_mosi(mosi), .i_sel_n(ss_n),
		.o_miso(miso_pin), .i_mode(mode), .i_tx(peer_tx), .o_rx(peer_rx));
	// Core clock
	initial
	begin
		i_clock = 0;
		forever #10 i_clock = ~i_clock;
	end
	// Hang guard, well above the whole sequence
	always @(posedge i_clock)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 30000)
		begin
			errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Classic single cycle; data taken at the ack edge
	// No limit of its own: the hang guard ends a stuck wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h00_0000, d};
		do @(posedge i_clock); while (ack !== 1'b1);
		rd = rdat[7:0];
		{cyc, stb} <= 2'b00;
	endtask
	// Poll status until the done flag shows, bounded
	task automatic wait_done();
		int t;
		t = 0;
		rd = 0;
		while (rd[7] !== 1'b1 && t++ < 600)
			wb(0, SA, 0);
		check(rd[7], 1);
	endtask
	task automatic t_regs();
		wb(0, CA, 0);
		check(rd, scr_pkg::CTRL_RESET);
		wb(1, CA, 8'hFF);
		wb(0, CA, 0);
		check(rd, 8'hFF);
		wb(1, CA, 8'h00);
		wb(0, 8'h00, 0);
		check(rd, 0);
		$display("register test done");
	endtask
	// One master byte in both directions
	task automatic xfer(input logic [7:0] m, t, p);
		mode = m;
		peer_tx = p;
		wb(1, CA, m);
		wb(1, SA, 8'h80);
		check(sck, m[3]);
		ss_n <= 0;
		wb(1, DA, t);
		wait_done();
		ss_n <= 1;
		check(sck, m[3]);
		check(peer_rx, t);
		wb(0, DA, 0);
		check(rd, p);
		$display("master transfer %h done", m);
	endtask
	task automatic t_irq();
		gie <= 0;
		xfer(8'hD1, 8'h5A, 8'hC3);
		check(irq, 0);
		gie <= 1;
		repeat (2) @(posedge i_clock);
		check(irq, 1);
		wb(1, CA, 8'h51);
		check(irq, 0);
		$display("interrupt test done");
	endtask
	task automatic t_rate();
		logic [31:0] h [4] = '{2, 8, 32, 64};
		time t0;
		for (int r = 0; r < 4; r++)
		begin
			wb(1, CA, 8'h50 | 8'(r));
			wb(1, SA, 8'h80);
			wb(1, DA, 8'h00);
			check({sck_oe, mosi_oe}, 2'b11);
			@(sck);
			t0 = $time;
			@(sck);
			check(32'(($time - t0) / 20), h[r]);
			wait_done();
		end
		$display("rate test done");
	endtask
	task automatic t_off();
		wb(1, CA, 8'h11);
		wb(1, SA, 8'h80);
		wb(1, DA, 8'hA5);
		repeat (40) @(posedge i_clock);
		check({sck_oe, mosi_oe, sck}, 3'b000);
		wb(0, SA, 0);
		check(rd[7], 0);
		$display("disable test done");
	endtask
	task automatic t_fault();
		wb(1, CA, 8'h51);
		{ssin, ss_n} <= 2'b10;
		wait_done();
		wb(0, CA, 0);
		check(rd, 8'h41);
		check(sck_oe, 0);
		{ssin, ss_n} <= 2'b01;
		wb(1, CA, 8'h51);
		wb(0, CA, 0);
		check(rd, 8'h51);
		$display("mode fault test done");
	endtask
	// Bench acts as master with the link clock made by hand
	task automatic t_slave();
		logic [7:0] got;
		wb(1, CA, 8'h40);
		wb(1, SA, 8'h80);
		wb(1, DA, 8'h96);
		check(miso_oe, 0);
		{ssin, ss_n} <= 2'b10;
		repeat (10) @(posedge i_clock);
		check(miso_oe, 1);
		// Reply bit read at the end of the high phase: the pin filter
		// puts about five core cycles between a link edge and the bit
		for (int i = 7; i >= 0; i--)
		begin
			mosi_in <= 1'(8'h3B >> i);
			repeat (4) @(posedge i_clock);
			sck_in <= 1;
			repeat (4) @(posedge i_clock);
			got[i] = miso;
			sck_in <= 0;
		end
		repeat (10) @(posedge i_clock);
		{ss_n, mosi_in} <= {1'b1, ~mosi_in};
		wait_done();
		check(got, 8'h96);
		wb(0, DA, 0);
		check(rd, 8'h3B);
		$display("slave test done");
	endtask
	initial
	begin
		{cyc, stb, we, adr, wdat, i_reset_n} = '0;
		{gie, ssin, sck_in, mosi_in, ss_n} = 5'b00001;
		{mode, peer_tx, errors, n_compared} = '0;
		repeat (12) @(posedge i_clock);
		i_reset_n <= 1;
		t_regs();
		xfer(8'h51, 8'hA1, 8'h3C);
		xfer(8'h5D, 8'h0F, 8'hE2);
		xfer(8'h75, 8'h81, 8'h6B);
		xfer(8'h79, 8'hC4, 8'h17);
		t_irq();
		t_rate();
		t_off();
		t_fault();
		t_slave();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
